// ==== test_trg_resp_gen.sv ====
// Self-checking bench for the target response generator
`timescale 1ns/1ps
module test_trg_resp_gen;
  localparam int DEPTH = 64;
  logic         mclk, sys_rst, treq_valid, treq_ready, tresp_valid, tresp_ready, tresp_has_data;
  logic [3:0]   treq_ftype, treq_ttype, tresp_ftype, tresp_ttype, tresp_status;
  logic [1:0]   treq_prio, tresp_prio;
  logic [7:0]   treq_tid, tresp_tid, fill;
  logic [15:0]  treq_src_id, treq_dst_id, tresp_src_id, tresp_dst_id;
  logic [33:0]  treq_addr;
  logic [63:0]  treq_data, tresp_data;
  logic [63:0]  mem_m [DEPTH];
  logic [110:0] exp_q [$];
  int           n_mismatch, samples_checked, cycles;
  logic [110:0] seen_w;
  logic [7:0]   cls_w;

  trg_resp_gen #(.MEM_DEPTH(DEPTH)) trg_resp_gen_i (.mclk, .sys_rst, .treq_valid, .treq_ready,
    .treq_ftype, .treq_ttype, .treq_prio, .treq_tid, .treq_src_id, .treq_dst_id, .treq_addr,
    .treq_data, .tresp_valid, .tresp_ready, .tresp_ftype, .tresp_ttype, .tresp_status,
    .tresp_prio, .tresp_tid, .tresp_src_id, .tresp_dst_id, .tresp_data, .tresp_has_data);
  trg_link_model link_i (.mclk, .sys_rst, .treq_valid, .treq_ready, .treq_ftype, .treq_ttype,
    .treq_prio, .treq_tid, .treq_src_id, .treq_dst_id, .treq_addr, .treq_data,
    .tresp_valid, .tresp_ready);

  // Response fields gathered in queue-note order
  assign seen_w = {tresp_ttype, tresp_prio, tresp_tid, tresp_dst_id, tresp_src_id, tresp_data,
                   tresp_has_data};
  assign cls_w  = {tresp_ftype, tresp_status};

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Compare and count
  task automatic check(input string what, input logic [110:0] e, input logic [110:0] s);
    samples_checked++;
    if (e !== s) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, e, s);
    end
  endtask

  // Report and end the run
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Response watcher takes the oldest note at each accepted response
  always @(posedge mclk) begin
    if (!sys_rst && tresp_valid === 1'b1 && tresp_ready === 1'b1) begin
      if (exp_q.size() == 0) check("unsolicited", '0, '1);
      else check("resp", exp_q.pop_front(), seen_w);
      check("class", 111'({trg_pkg::FT_RESP, trg_pkg::ST_DONE}), 111'(cls_w));
    end
  end

  // Cut a hang short
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 8000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // One request of kind k: bit 0 picks scratch, upper part picks the type
  task automatic one(input int k);
    logic [3:0]  ft, tt;
    logic [1:0]  pr, pe;
    logic [7:0]  id;
    logic [15:0] src, dst, hi;
    logic [5:0]  ix;
    logic [63:0] dt, rd;
    pr = 2'($urandom); id = 8'($urandom); src = 16'($urandom); dst = 16'($urandom);
    dt = {32'($urandom), 32'($urandom)};
    ix = ($urandom % 3 == 0) ? 6'h3f : 6'($urandom % 4);
    hi = k[0] ? trg_pkg::SCR_BASE : (16'($urandom) | 16'h8000);
    case (k >> 1)
      0: {ft, tt} = {trg_pkg::FT_NREAD, trg_pkg::TT_NREAD};
      1: {ft, tt} = {trg_pkg::FT_WRITE, trg_pkg::TT_NWRITE};
      2: {ft, tt} = {trg_pkg::FT_WRITE, trg_pkg::TT_NWRITE_R};
      3: {ft, tt} = {trg_pkg::FT_SWRITE, 4'($urandom)};
      default: {ft, tt} = {trg_pkg::FT_DBELL, 4'h0};
    endcase
    pe = (pr == trg_pkg::PRIO_MAX) ? pr : pr + 2'h1;
    if (ft == trg_pkg::FT_NREAD) begin
      rd = mem_m[ix];
      if (!k[0]) begin
        for (int b = 0; b < 8; b++) rd[8*b +: 8] = fill + 8'(b);
        fill = fill + trg_pkg::FILL_STEP;
      end
      exp_q.push_back({trg_pkg::TT_RESP_D, pe, id, src, dst, rd, 1'b1});
    end
    if (ft == trg_pkg::FT_WRITE && k[0]) mem_m[ix] = dt;
    if (ft == trg_pkg::FT_DBELL || (ft == trg_pkg::FT_WRITE && tt == trg_pkg::TT_NWRITE_R))
      exp_q.push_back({trg_pkg::TT_RESP_ND, pe, id, src, dst, 64'h0, 1'b0});
    link_i.send(ft, tt, pr, id, src, dst, {2'($urandom), hi, 7'($urandom), ix, 3'($urandom)}, dt);
  endtask

  // Main sequence
  initial begin
    void'($urandom(32'heb925de0));
    {n_mismatch, samples_checked, cycles} = '0;
    sys_rst = 1'b1;
    fill = trg_pkg::FILL_RST;
    foreach (mem_m[i]) mem_m[i] = '0;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    for (int k = 0; k < 10; k++) one(k);
    for (int i = 0; i < 400; i++) one(int'($urandom % 10));
    link_i.idle();
    for (int w = 0; w < 60 && exp_q.size() != 0; w++) @(posedge mclk);
    repeat (4) @(posedge mclk);
    check("pending", '0, 111'(exp_q.size()));
    tally_and_finish();
  end
endmodule // test_trg_resp_gen

// ==== trg_link_model.sv ====
// Link partner model: issues target requests and accepts responses
`timescale 1ns/1ps
module trg_link_model (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Request side
  output logic             treq_valid,
  input  wire logic        treq_ready,
  output logic [3:0]       treq_ftype,
  output logic [3:0]       treq_ttype,
  output logic [1:0]       treq_prio,
  output logic [7:0]       treq_tid,
  output logic [15:0]      treq_src_id,
  output logic [15:0]      treq_dst_id,
  output logic [33:0]      treq_addr,
  output logic [63:0]      treq_data,
  // Response side
  input  wire logic        tresp_valid,
  output logic             tresp_ready
);
  // Quiet lines at time zero
  initial begin
    {treq_valid, treq_ftype, treq_ttype, treq_prio, treq_tid} = '0;
    {treq_src_id, treq_dst_id, treq_addr, treq_data, tresp_ready} = '0;
  end

  // Accept responses with random stalls so outputs must stand
  always @(posedge mclk) tresp_ready <= ($urandom % 4) != 0;

  // Present one request and hold it until the edge that takes it
  task automatic send(input logic [3:0] ft, input logic [3:0] tt, input logic [1:0] pr,
                      input logic [7:0] id, input logic [15:0] src, input logic [15:0] dst,
                      input logic [33:0] ad, input logic [63:0] dt);
    {treq_ftype, treq_ttype, treq_prio, treq_tid} <= {ft, tt, pr, id};
    {treq_src_id, treq_dst_id, treq_addr, treq_data} <= {src, dst, ad, dt};
    treq_valid <= 1'b1;
    do @(negedge mclk); while (treq_ready !== 1'b1 || sys_rst);
    @(posedge mclk);
  endtask

  // Release the request; payload no longer shows the old value
  task automatic idle();
    treq_valid <= 1'b0;
    treq_data  <= ~treq_data;
  endtask
endmodule // trg_link_model

// ==== trg_pkg.sv ====
// Constants and types shared by the target response generator
package trg_pkg;

  // ----------------------------------------------------------------
  // Packet type codes
  // ----------------------------------------------------------------
  localparam logic [3:0] FT_NREAD    = 4'h2;  // Read class
  localparam logic [3:0] FT_WRITE    = 4'h5;  // Write class
  localparam logic [3:0] FT_SWRITE   = 4'h6;  // Streaming write
  localparam logic [3:0] FT_DBELL    = 4'ha;  // Doorbell
  localparam logic [3:0] FT_RESP     = 4'hd;  // Response class
  localparam logic [3:0] TT_NREAD    = 4'h4;  // Plain read
  localparam logic [3:0] TT_NWRITE   = 4'h4;  // Write, no answer
  localparam logic [3:0] TT_NWRITE_R = 4'h5;  // Write, answer wanted
  localparam logic [3:0] TT_RESP_ND  = 4'h0;  // Response without data
  localparam logic [3:0] TT_RESP_D   = 4'h8;  // Response with data
  localparam logic [3:0] ST_DONE     = 4'h0;  // Status done

  // ----------------------------------------------------------------
  // Scratch region and payload layout
  // ----------------------------------------------------------------
  localparam logic [15:0] SCR_BASE   = 16'h0012;  // Upper address half of scratch space
  localparam int          SCR_HI     = 31;
  localparam int          SCR_LO     = 16;
  localparam int          DW_LSB     = 3;         // Doubleword index starts here
  localparam int          DATA_W     = 64;
  localparam int          SCR_DWORDS = 8192;      // Doublewords in the scratch window
  localparam logic [7:0]  FILL_RST   = 8'h00;     // First filler byte after reset
  localparam logic [7:0]  FILL_STEP  = 8'h08;     // Filler advance per read response outside scratch
  localparam logic [1:0]  PRIO_MAX   = 2'h3;

  // ----------------------------------------------------------------
  // Control states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TRG_IDLE = 2'b01,
    TRG_RESP = 2'b10
  } trg_state_t;

endpackage

// ==== trg_resp_gen.sv ====
// Target response generator for incoming I/O requests
`timescale 1ns/1ps

// Operation
// - Responses are produced only for requests taken from the target request stream.
// - TT_NWRITE and TT_NWRITE_R writes to the scratch region store their payload at the addressed location; streaming writes do not.
// - Writes outside scratch needing no answer are dropped with no memory change.
// - Streaming writes never get any response, whatever their address.
// - Scratch reads return the memory content currently at the requested address.
// - Reads outside scratch return an incrementing byte pattern.
// - Responses leave strictly in request arrival order.
// - Response priority equals request priority plus one, held at PRIO_MAX when the request is already at PRIO_MAX.
module trg_resp_gen #(
  parameter int MEM_DEPTH = 64,
  parameter int ADDR_W    = 34
) (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 sys_rst,
  // Target request stream
  input  wire logic                 treq_valid,
  output logic                      treq_ready,
  input  wire logic [3:0]           treq_ftype,
  input  wire logic [3:0]           treq_ttype,
  input  wire logic [1:0]           treq_prio,
  input  wire logic [7:0]           treq_tid,
  input  wire logic [15:0]          treq_src_id,
  input  wire logic [15:0]          treq_dst_id,
  input  wire logic [ADDR_W-1:0]    treq_addr,
  input  wire logic [63:0]          treq_data,
  // Target response stream
  output logic                      tresp_valid,
  input  wire logic                 tresp_ready,
  output logic [3:0]                tresp_ftype,
  output logic [3:0]                tresp_ttype,
  output logic [3:0]                tresp_status,
  output logic [1:0]                tresp_prio,
  output logic [7:0]                tresp_tid,
  output logic [15:0]               tresp_src_id,
  output logic [15:0]               tresp_dst_id,
  output logic [63:0]               tresp_data,
  output logic                      tresp_has_data
);

  localparam int IDX_W = $clog2(MEM_DEPTH);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (MEM_DEPTH < 2 || MEM_DEPTH > trg_pkg::SCR_DWORDS || (MEM_DEPTH & (MEM_DEPTH - 1)) != 0)
    $error("MEM_DEPTH must be a power of two between 2 and the scratch window size");
  if (ADDR_W <= trg_pkg::SCR_HI)
    $error("ADDR_W too narrow to hold the scratch region decode");

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    trg_pkg::trg_state_t              state;
    logic [MEM_DEPTH-1:0][63:0]       mem;
    logic [7:0]                       fill;
    logic [3:0]                       ttype;
    logic [1:0]                       prio;
    logic [7:0]                       tid;
    logic [15:0]                      src_id;
    logic [15:0]                      dst_id;
    logic [63:0]                      data;
    logic                             has_data;
  } trg_regs_t;

  trg_regs_t  st_r;
  trg_regs_t  st_nxt;

  logic             take;
  logic             in_scratch;
  logic             is_read;
  logic             is_nwr;
  logic             is_nwr_r;
  logic             is_swr;
  logic             is_dbell;
  logic             need_resp;
  logic [IDX_W-1:0] idx;
  logic [63:0]      fill_data;

  // Request decode
  assign idx        = treq_addr[trg_pkg::DW_LSB +: IDX_W];
  assign in_scratch = treq_addr[trg_pkg::SCR_HI:trg_pkg::SCR_LO] == trg_pkg::SCR_BASE;
  assign is_read    = treq_ftype == trg_pkg::FT_NREAD && treq_ttype == trg_pkg::TT_NREAD;
  assign is_nwr     = treq_ftype == trg_pkg::FT_WRITE && treq_ttype == trg_pkg::TT_NWRITE;
  assign is_nwr_r   = treq_ftype == trg_pkg::FT_WRITE && treq_ttype == trg_pkg::TT_NWRITE_R;
  assign is_swr     = treq_ftype == trg_pkg::FT_SWRITE;
  assign is_dbell   = treq_ftype == trg_pkg::FT_DBELL;
  assign need_resp  = is_read || is_nwr_r || is_dbell;
  assign take       = treq_valid && treq_ready;

  // Handshakes: one request in flight at a time keeps answers in order
  assign treq_ready  = st_r.state == trg_pkg::TRG_IDLE;
  assign tresp_valid = st_r.state == trg_pkg::TRG_RESP;

  // Response fields: class and status constant, the rest from registers
  assign tresp_ftype    = trg_pkg::FT_RESP;
  assign tresp_status   = trg_pkg::ST_DONE;
  assign tresp_ttype    = st_r.ttype;
  assign tresp_prio     = st_r.prio;
  assign tresp_tid      = st_r.tid;
  assign tresp_src_id   = st_r.src_id;
  assign tresp_dst_id   = st_r.dst_id;
  assign tresp_data     = st_r.data;
  assign tresp_has_data = st_r.has_data;

  // Incrementing filler, one byte per lane, lowest lane first
  for (genvar g = 0; g < 8; g++) begin : g_fill
    assign fill_data[g*8 +: 8] = st_r.fill + 8'(g);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    case (st_r.state)
      trg_pkg::TRG_IDLE: begin
        if (take) begin
          // Non-streaming scratch writes land in memory, others leave it alone
          if ((is_nwr || is_nwr_r) && in_scratch) begin
            st_nxt.mem[idx] = treq_data;
          end
          if (need_resp) begin
            st_nxt.state  = trg_pkg::TRG_RESP;
            st_nxt.ttype  = is_read ? trg_pkg::TT_RESP_D : trg_pkg::TT_RESP_ND;
            st_nxt.prio   = (treq_prio == trg_pkg::PRIO_MAX) ? trg_pkg::PRIO_MAX
                                                             : treq_prio + 2'h1;
            st_nxt.tid    = treq_tid;
            st_nxt.dst_id = treq_src_id;
            st_nxt.src_id = treq_dst_id;
            st_nxt.has_data = is_read;
            st_nxt.data   = 64'h0;
            if (is_read && in_scratch) begin
              st_nxt.data = st_r.mem[idx];
            end else if (is_read) begin
              st_nxt.data = fill_data;
              st_nxt.fill = st_r.fill + trg_pkg::FILL_STEP;
            end
          end
        end
      end
      trg_pkg::TRG_RESP: begin
        if (tresp_ready) begin
          st_nxt.state = trg_pkg::TRG_IDLE;
        end
      end
      default: begin
        st_nxt.state = trg_pkg::TRG_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r       <= '0;
      st_r.state <= trg_pkg::TRG_IDLE;
      st_r.fill  <= trg_pkg::FILL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  property p_resp_cause;
    $rose(tresp_valid) |-> $past(take && need_resp);
  endproperty
  a_resp_cause: assert property (p_resp_cause) else $error("response without request");

  property p_scr_write;
    take && (is_nwr || is_nwr_r) && in_scratch |=> st_r.mem[$past(idx)] == $past(treq_data);
  endproperty
  a_scr_write: assert property (p_scr_write) else $error("scratch write not stored");

  property p_drop_write;
    take && is_nwr && !in_scratch |=> $stable(st_r.mem) && !tresp_valid;
  endproperty
  a_drop_write: assert property (p_drop_write) else $error("dropped write had effect");

  // A later request may be answered one cycle on; only that may raise valid then
  property p_no_swrite;
    take && is_swr |=> !tresp_valid ##1 (!tresp_valid || $past(take && need_resp));
  endproperty
  a_no_swrite: assert property (p_no_swrite) else $error("streaming write answered");

  property p_scr_read;
    take && is_read && in_scratch |=> tresp_valid && tresp_has_data
                                      && tresp_data == $past(st_r.mem[idx]);
  endproperty
  a_scr_read: assert property (p_scr_read) else $error("scratch read data wrong");

  property p_fill_read;
    take && is_read && !in_scratch |=> tresp_data[15:8] == tresp_data[7:0] + 8'h01
                                       && tresp_data[7:0] == $past(st_r.fill);
  endproperty
  a_fill_read: assert property (p_fill_read) else $error("filler pattern wrong");

  property p_order;
    tresp_valid && !tresp_ready |=> tresp_valid && !treq_ready && $stable(tresp_tid);
  endproperty
  a_order: assert property (p_order) else $error("response overtaken or dropped");

  property p_prio;
    take && need_resp && treq_prio != 2'h3 |=> tresp_prio == $past(treq_prio) + 2'h1;
  endproperty
  a_prio: assert property (p_prio) else $error("response priority wrong");

  property p_ids;
    take && need_resp |=> tresp_tid == $past(treq_tid) && tresp_dst_id == $past(treq_src_id);
  endproperty
  a_ids: assert property (p_ids) else $error("response identifiers wrong");

  c_scr_read:  cover property (take && is_read && in_scratch ##1 tresp_valid);
  c_fill_read: cover property (take && is_read && !in_scratch ##1 tresp_valid);
  c_write_r:   cover property (take && is_nwr_r && in_scratch ##1 tresp_valid && tresp_ready);
  c_stall:     cover property ((tresp_valid && !tresp_ready) [*3]);

endmodule // trg_resp_gen
